//--- hdl/sram_wr_ctrl.sv
// Write-side controller driving an asynchronous 32-bit static memory
`timescale 1ns/1ps
`include "sram_wr_map.svh"

// How it works
// - Overlap of four controls defines write
// - Each control held for its minimum width
// - Overlap of all controls covers minimum pulse
// - Address valid before start, stable throughout
// - Address held after the ending control
// - Data valid a setup before write end
// - Data held after the write ends
// - Drive data only after memory output floats
// - Recovery gap between back-to-back writes
// - Single toggled control, others stay enabling
// - Successive writes respect minimum cycle time
module sram_wr_ctrl
    import sram_wr_pkg::*;
(
    input  wire logic               i_sys_clk,
    input  wire logic               i_srst,
    input  wire logic               i_req_valid,
    input  wire wr_req_t            i_req,
    output logic                    o_req_ready,
    output logic                    o_done,
    output mem_ctl_t                o_mem_ctl,
    output logic [`ADDR_W-1:0]      o_mem_addr,
    output logic [`DATA_W-1:0]      o_mem_dq_out,
    output logic [`DATA_W-1:0]      o_mem_dq_oe
);

    // Cycle counts derived from the memory minimums. Every phase is at least
    // one cycle, even when the memory minimum is zero. That costs a little
    // throughput, but no edge ever lands at the same instant as the edge it
    // depends on, so board skew cannot reorder them.
    localparam logic [`CNT_W-1:0] SETUP_CYC   = `CNT_W'(`CYC_UP(`OUTPUT_FLOAT_DELAY));
    localparam logic [`CNT_W-1:0] STROBE_A    = `CNT_W'(`CYC_UP(`WRITE_STROBE_MIN_WIDTH));
    localparam logic [`CNT_W-1:0] STROBE_D    = `CNT_W'(`CYC_UP(`DATA_SETUP_TO_END));
    localparam logic [`CNT_W-1:0] STROBE_E    = `CNT_W'(`CYC_UP(`ADDR_SETUP_TO_END));
    localparam logic [`CNT_W-1:0] STROBE_B    = (STROBE_A > STROBE_D) ? STROBE_A : STROBE_D;
    localparam logic [`CNT_W-1:0] STROBE_CYC  = (STROBE_B > STROBE_E) ? STROBE_B : STROBE_E;
    localparam logic [`CNT_W-1:0] HOLD_A      = `CNT_W'(`CYC_UP(`ADDR_HOLD_AFTER_END));
    localparam logic [`CNT_W-1:0] HOLD_D      = `CNT_W'(`CYC_UP(`DATA_HOLD_AFTER_END));
    localparam logic [`CNT_W-1:0] HOLD_CYC    = (HOLD_A > HOLD_D) ? HOLD_A : HOLD_D;
    localparam logic [`CNT_W-1:0] RECOVER_CYC = `CNT_W'(`CYC_UP(`WRITE_RECOVERY_MIN));
    localparam logic [`CNT_W-1:0] CYCLE_CYC   = `CNT_W'(`CYC_UP(`WRITE_CYCLE_MIN));
    localparam logic [`CNT_W-1:0] CNT_ONE     = `CNT_W'(1);

    wr_state_t          state_r;
    wr_state_t          state_nxt;
    logic [`CNT_W-1:0]  cnt_r;
    logic [`CNT_W-1:0]  cycle_r;
    wr_req_t            req_r;
    logic               cnt_last;

    assign cnt_last = (cnt_r == CNT_ONE);

    // Next state; each phase lasts its rounded-up cycle count
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (i_req_valid) begin
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt_last) begin
                    state_nxt = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (cnt_last) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_last) begin
                    state_nxt = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // Both recovery and the whole cycle time must have elapsed
                if (cnt_last && cycle_r == '0) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Phase counter, loaded on every phase entry
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cnt_r <= '0;
        end else if (state_nxt != state_r) begin
            case (state_nxt)
                ST_SETUP:   cnt_r <= SETUP_CYC;
                ST_STROBE:  cnt_r <= STROBE_CYC;
                ST_HOLD:    cnt_r <= HOLD_CYC;
                ST_RECOVER: cnt_r <= RECOVER_CYC;
                default:    cnt_r <= '0;
            endcase
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - CNT_ONE;
        end
    end

    // Write cycle timer, started with the strobe's falling edge
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cycle_r <= '0;
        end else if (state_r == ST_SETUP && cnt_last) begin
            cycle_r <= CYCLE_CYC - CNT_ONE;
        end else if (cycle_r != '0) begin
            cycle_r <= cycle_r - CNT_ONE;
        end
    end

    // Request capture; address and data stay fixed until the next accept
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            req_r <= '0;
        end else if (state_r == ST_IDLE && i_req_valid) begin
            req_r <= i_req;
        end
    end

    // Handshake outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_req_ready <= 1'b0;
            o_done      <= 1'b0;
        end else begin
            o_req_ready <= (state_nxt == ST_IDLE) && !(state_r == ST_IDLE && i_req_valid);
            o_done      <= (state_r == ST_RECOVER) && (state_nxt == ST_IDLE);
        end
    end

    // Memory pins: select, enable and lanes frame the whole access, the strobe
    // alone opens and closes the write so one toggled control bounds it.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_mem_ctl.write_strobe_n <= 1'b1;
            o_mem_ctl.select_n       <= 1'b1;
            o_mem_ctl.chip_enable    <= 1'b0;
            o_mem_ctl.output_drive_n <= 1'b1;
            o_mem_ctl.lane_enable_n  <= '1;
            o_mem_addr               <= '0;
        end else begin
            o_mem_ctl.output_drive_n <= 1'b1; // keeps memory outputs off
            o_mem_ctl.write_strobe_n <= !(state_nxt == ST_STROBE);
            o_mem_ctl.select_n       <= (state_nxt == ST_IDLE);
            o_mem_ctl.chip_enable    <= (state_nxt != ST_IDLE);
            if (state_r == ST_IDLE && i_req_valid) begin
                o_mem_ctl.lane_enable_n <= ~i_req.lanes;
                o_mem_addr              <= i_req.addr;
            end else if (state_nxt == ST_IDLE) begin
                o_mem_ctl.lane_enable_n <= '1;
            end
        end
    end

    // Data drive starts one setup phase after select, so the float delay has passed
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_mem_dq_out <= '0;
            o_mem_dq_oe  <= '0;
        end else begin
            if (state_nxt == ST_STROBE || state_nxt == ST_HOLD) begin
                o_mem_dq_oe <= '1;
            end else begin
                o_mem_dq_oe <= '0;
            end
            o_mem_dq_out <= req_r.data;
        end
    end

    // Strobe low only while select and enable are both active
    strobe_frame_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !o_mem_ctl.write_strobe_n |-> !o_mem_ctl.select_n && o_mem_ctl.chip_enable)
        else $error("strobe low outside select frame");

    // Strobe low lasts the one strobe cycle this clock needs, then returns high
    strobe_width_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $fell(o_mem_ctl.write_strobe_n) |-> (!o_mem_ctl.write_strobe_n)[*1] ##1 o_mem_ctl.write_strobe_n)
        else $error("strobe width wrong");

    // Address stable during the write and one cycle after it
    addr_stable_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !o_mem_ctl.write_strobe_n |=> $stable(o_mem_addr))
        else $error("address changed during write");

    // Data driven throughout strobe and one cycle past its end
    data_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_mem_ctl.write_strobe_n) |-> o_mem_dq_oe == '1 && $stable(o_mem_dq_out))
        else $error("data dropped at write end");

    // Data drive never follows select by less than one cycle
    data_late_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_mem_ctl.chip_enable) |-> o_mem_dq_oe == '0)
        else $error("data driven with select");

    // Strobe returns high at least one cycle between writes
    recovery_gap_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_mem_ctl.write_strobe_n) |=> o_mem_ctl.write_strobe_n)
        else $error("no recovery gap");

    // Memory output buffers stay off throughout
    out_float_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_mem_ctl.output_drive_n)
        else $error("memory output enabled");

    // Lane pattern steady while the strobe is low
    lane_steady_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !o_mem_ctl.write_strobe_n |=> $stable(o_mem_ctl.lane_enable_n))
        else $error("lanes changed in write");

    // Memory is deselected when an access completes
    deselect_done_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_done |-> o_mem_ctl.select_n && !o_mem_ctl.chip_enable)
        else $error("select held after done");

    // No lane stays enabled while the memory is deselected
    lanes_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_mem_ctl.select_n |-> o_mem_ctl.lane_enable_n == '1)
        else $error("lane enabled while idle");

    // Select is already active before the strobe falls, so the strobe alone
    // opens the overlap whatever the skew on the board
    strobe_inside_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $fell(o_mem_ctl.write_strobe_n) |-> $past(!o_mem_ctl.select_n))
        else $error("strobe opened before select");

    // Data is driven for the whole strobe, which covers the data setup
    data_setup_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $fell(o_mem_ctl.write_strobe_n) |-> o_mem_dq_oe == '1)
        else $error("data missing at strobe");

    // Ready is only shown while the memory is deselected
    ready_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_req_ready |-> o_mem_ctl.select_n)
        else $error("ready during access");

    // Done is a single cycle pulse
    done_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_done |=> !o_done)
        else $error("done longer than a cycle");

    // Address still held in the cycle after the strobe ends
    addr_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_mem_ctl.write_strobe_n) |=> $stable(o_mem_addr))
        else $error("address dropped after write");

    // Data drive starts only after the memory has been selected a full cycle
    // with its outputs off, so the output float delay has run out
    drive_late_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_mem_dq_oe[0]) |-> o_mem_ctl.output_drive_n && $past(!o_mem_ctl.select_n))
        else $error("data driven too early");

    // A limitation worth knowing: the strobe is the only bounding control, so
    // a board that gates select separately must still meet the strobe timing.

endmodule

//--- hdl/sram_wr_map.svh
// Timing figures and field widths of the static memory write port
`ifndef SRAM_WR_MAP_SVH
`define SRAM_WR_MAP_SVH

`define CLK_PERIOD_NS          20
`define ADDR_W                 19
`define DATA_W                 32
`define LANES                  4
`define LANE_W                 8
// Memory minimum times in ns
`define WRITE_STROBE_MIN_WIDTH 7
`define WRITE_RECOVERY_MIN     5
`define WRITE_CYCLE_MIN        12
`define ADDR_SETUP_TO_START    0
`define ADDR_SETUP_TO_END      12
`define ADDR_HOLD_AFTER_END    0
`define DATA_SETUP_TO_END      6
`define DATA_HOLD_AFTER_END    0
`define OUTPUT_FLOAT_DELAY     4
// Least times round up to whole cycles, never below one
`define CYC_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CNT_W                  4

`endif

//--- hdl/sram_wr_pkg.sv
// Types shared by the static memory write controller
package sram_wr_pkg;
    `include "sram_wr_map.svh"

    // One write request from the user side
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
        logic [`LANES-1:0]  lanes;
    } wr_req_t;

    // Memory-facing control pins, active levels as on the device
    typedef struct packed {
        logic               write_strobe_n;
        logic               select_n;
        logic               chip_enable;
        logic               output_drive_n;
        logic [`LANES-1:0]  lane_enable_n;
    } mem_ctl_t;

    // Gray coded along idle -> setup -> strobe -> hold -> recover
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SETUP   = 3'b001,
        ST_STROBE  = 3'b011,
        ST_HOLD    = 3'b010,
        ST_RECOVER = 3'b110
    } wr_state_t;
endpackage

//--- tb/async_sram_write_port_tb_top.sv
// Self-checking testbench for the static memory write controller
`timescale 1ns/1ps
`include "sram_wr_map.svh"
module async_sram_write_port_tb_top
    import sram_wr_pkg::*;
;
    logic               i_sys_clk = 1'b0;
    logic               i_srst = 1'b1;
    logic               i_req_valid = 1'b0;
    wr_req_t            i_req = '0;
    logic               o_req_ready;
    logic               o_done;
    mem_ctl_t           o_mem_ctl;
    logic [`ADDR_W-1:0] o_mem_addr;
    logic [`DATA_W-1:0] o_mem_dq_out;
    logic [`DATA_W-1:0] o_mem_dq_oe;
    logic [`DATA_W-1:0] q;
    logic [`DATA_W-1:0] dq_bus;
    logic               q_oe;
    int                 err_total = 0;
    int                 compares = 0;

    always #(`CLK_PERIOD_NS/2) i_sys_clk = ~i_sys_clk;
    // Undriven bits show the inverse so a stale value never passes
    assign dq_bus = (o_mem_dq_oe & o_mem_dq_out) | (~o_mem_dq_oe & (q_oe ? q : ~o_mem_dq_out));

    sram_wr_ctrl DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ready(o_req_ready), .o_done(o_done), .o_mem_ctl(o_mem_ctl), .o_mem_addr(o_mem_addr),
        .o_mem_dq_out(o_mem_dq_out), .o_mem_dq_oe(o_mem_dq_oe));
    sram_mem_model u_mem (.i_ctl(o_mem_ctl), .i_addr(o_mem_addr), .i_dq(dq_bus), .i_dq_oe(o_mem_dq_oe),
        .o_q(q), .o_q_oe(q_oe));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One write from a falling edge; hold keeps valid up for a back-to-back request
    task automatic do_write(input logic [18:0] a, input logic [31:0] d, input logic [3:0] ln, input bit hold);
        int         n;
        logic [4:0] sel;
        logic [4:0] str;
        logic [3:0] lseen;
        logic       dn;
        logic [18:0] ad;
        logic       ce;
        n = 0;
        i_req_valid = 1'b1;
        i_req = '{addr: a, data: d, lanes: ln};
        while (o_req_ready !== 1'b1 && n < 50) begin
            @(negedge i_sys_clk);
            n++;
        end
        @(posedge i_sys_clk);
        for (int c = 0; c < 5; c++) begin
            @(negedge i_sys_clk);
            if (c == 0 && !hold) i_req_valid = 1'b0;
            sel[c] = o_mem_ctl.select_n;
            str[c] = o_mem_ctl.write_strobe_n;
            if (c == 1) lseen = ~o_mem_ctl.lane_enable_n;
            if (c == 1) ad = o_mem_addr;
            if (c == 1) ce = o_mem_ctl.chip_enable;
            if (c == 4) dn = o_done;
        end
        chk({27'h0, sel}, 32'h10);
        chk({27'h0, str}, 32'h1D);
        chk({31'h0, dn}, 32'h1);
        chk({28'h0, lseen}, {28'h0, ln});
        chk({13'h0, ad}, {13'h0, a});
        chk({31'h0, ce}, 32'h1);
        chk(32'(u_mem.viol), 32'h0);
    endtask

    task automatic t_reset();
        chk({27'h0, o_mem_ctl.write_strobe_n, o_mem_ctl.select_n, o_mem_ctl.chip_enable, o_req_ready,
            |o_mem_dq_oe}, 32'h18);
    endtask

    task automatic t_full();
        do_write(19'h7FFFF, 32'hA5C3_0F96, 4'hF, 1'b0);
        chk(u_mem.mem[19'h7FFFF], 32'hA5C3_0F96);
    endtask

    // Each pattern merges into a word that was first filled with ones
    task automatic t_lanes();
        logic [3:0]  pats [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h9};
        logic [31:0] exp;
        foreach (pats[p]) begin
            do_write(19'h00010, 32'hFFFF_FFFF, 4'hF, 1'b0);
            do_write(19'h00010, 32'h1122_3344, pats[p], 1'b0);
            for (int i = 0; i < 4; i++)
                exp[8*i +: 8] = pats[p][i] ? 8'(32'h1122_3344 >> (8*i)) : 8'hFF;
            chk(u_mem.mem[19'h00010], exp);
        end
    endtask

    // Valid stays up across the first write, so spacing is the controller's own
    task automatic t_back();
        do_write(19'h00100, 32'h0BAD_F00D, 4'hF, 1'b1);
        do_write(19'h00101, 32'hC0DE_1234, 4'hF, 1'b0);
        chk(u_mem.mem[19'h00100], 32'h0BAD_F00D);
        chk(u_mem.mem[19'h00101], 32'hC0DE_1234);
    endtask

    initial begin
        repeat (5) @(negedge i_sys_clk);
        t_reset();
        i_srst = 1'b0;
        @(negedge i_sys_clk);
        t_full();
        t_lanes();
        t_back();
        end_of_test();
    end

    // Watchdog well beyond the roughly 80 cycles the tests need
    initial begin
        #(`CLK_PERIOD_NS * 400);
        err_total++;
        end_of_test();
    end
endmodule

//--- tb/sram_mem_model.sv
// Behavioural model of the static memory write side with timing watch
`timescale 1ns/1ps
`include "sram_wr_map.svh"
module sram_mem_model
    import sram_wr_pkg::*;
(
    input  wire mem_ctl_t           i_ctl,
    input  wire logic [`ADDR_W-1:0] i_addr,
    input  wire logic [`DATA_W-1:0] i_dq,
    input  wire logic [`DATA_W-1:0] i_dq_oe,
    output logic [`DATA_W-1:0]      o_q,
    output logic                    o_q_oe
);
    logic [`DATA_W-1:0] mem [int];
    int                 viol = 0;
    realtime            t_start = -1000.0;
    realtime            t_end = -1000.0;
    realtime            t_data = 0.0;
    wire                act = !i_ctl.write_strobe_n && !i_ctl.select_n && i_ctl.chip_enable;
    // Drive only when read, so a low write strobe floats the outputs
    assign o_q_oe = !i_ctl.output_drive_n && !i_ctl.select_n && i_ctl.chip_enable && i_ctl.write_strobe_n;
    always @* begin
        o_q = mem.exists(i_addr) ? mem[i_addr] : ~i_dq;
    end
    // Timing watch on the controller side
    always @(i_dq) t_data = $realtime;
    always @(i_addr) if (act) viol++;
    always @(i_addr) if ($realtime == t_end) viol++;
    always @* if (o_q_oe && |i_dq_oe) viol++;
    always @(posedge act) begin
        if ($realtime - t_end < `WRITE_RECOVERY_MIN) viol++;
        if ($realtime - t_start < `WRITE_CYCLE_MIN) viol++;
        t_start = $realtime;
    end
    // Lanes latch at the close of the overlap; hold time is zero, so data is still valid here
    always @(negedge act) begin
        if (t_start >= 0.0) begin
            if ($realtime - t_start < `WRITE_STROBE_MIN_WIDTH) viol++;
            if ($realtime - t_data < `DATA_SETUP_TO_END) viol++;
            t_end = $realtime;
            for (int i = 0; i < `LANES; i++)
                if (!i_ctl.lane_enable_n[i]) mem[i_addr][8*i +: 8] = i_dq[8*i +: 8];
        end
    end
endmodule
